/* common/rrv_pkg.sv */
package rrv_pkg;

   // Re-validation setting codes and the divided-period counts they select
   localparam logic [1:0] REVAL_SEL_RESET = 2'h0;
   localparam int REVAL_CNT_W = 7;
   localparam logic [REVAL_CNT_W-1:0] REVAL_CNT_00 = 7'h02;
   localparam logic [REVAL_CNT_W-1:0] REVAL_CNT_01 = 7'h10;
   localparam logic [REVAL_CNT_W-1:0] REVAL_CNT_10 = 7'h20;
   localparam logic [REVAL_CNT_W-1:0] REVAL_CNT_11 = 7'h40;

   // Pre-divider codes: 00 = /1, 01 = /2, 10 = /4, 11 = /8
   localparam logic [1:0] PREDIV_RESET = 2'h0;
   localparam int PREDIV_W = 3;

   // Selection mode codes; bit 0 set means automatic selection
   localparam logic [1:0] MODE_MANUAL = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [1:0] MODE_SHORT_HOLD = 2'h2;
   localparam logic [1:0] MODE_AUTO_HOLD = 2'h3;
   localparam int MODE_AUTO_BIT = 0;

   // Missing-edge window: longest gap between raw input edges
   localparam int CLK_PERIOD_NS = 50;
   localparam int REF_MISS_NS = 2000;
   localparam int REF_MISS_CYC_CALC = (REF_MISS_NS / CLK_PERIOD_NS < 1) ? 1 :
      REF_MISS_NS / CLK_PERIOD_NS;
   localparam int MISS_W = 16;

   typedef enum logic [1:0] {
      SEL_CLK0 = 2'b00,
      SEL_CLK1 = 2'b01,
      SEL_HOLD = 2'b10
   } rrv_sel_state_t;

   typedef struct packed {
      logic [1:0] count_sel;
      logic [1:0] mode;
      logic man_sel;
      logic prio_in;
   } rrv_cfg_t;

   function automatic logic [REVAL_CNT_W-1:0] reval_load(input logic [1:0] sel);
      logic [REVAL_CNT_W-1:0] v;
      v = REVAL_CNT_00;
      case (sel)
         2'h1: v = REVAL_CNT_01;
         2'h2: v = REVAL_CNT_10;
         2'h3: v = REVAL_CNT_11;
         default: v = REVAL_CNT_00;
      endcase
      return v;
   endfunction

   function automatic logic [PREDIV_W-1:0] prediv_last(input logic [1:0] code);
      logic [PREDIV_W-1:0] v;
      v = 3'h0;
      case (code)
         2'h1: v = 3'h1;
         2'h2: v = 3'h3;
         2'h3: v = 3'h7;
         default: v = 3'h0;
      endcase
      return v;
   endfunction

endpackage

/* design/rrv_channel.sv */
`timescale 1ns/100ps
module rrv_channel
   import rrv_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic period_ok,
   input wire logic edge_miss,
   input wire logic [1:0] count_sel,
   output logic los_q,
   output logic [REVAL_CNT_W-1:0] cnt_q
);

   // A missing edge outranks a decrement, so a loss event is never lost to a re-validation
   always_ff @(posedge clk) begin
      if (rst) begin
         los_q <= 1'b1;
         cnt_q <= REVAL_CNT_00;
      end else if (edge_miss) begin
         los_q <= 1'b1;
         cnt_q <= reval_load(count_sel); // RQ1 RQ3
      end else if (los_q && period_ok) begin
         if (cnt_q == 7'h01) begin
            cnt_q <= 7'h00;
            los_q <= 1'b0; // RQ4
         end else begin
            cnt_q <= cnt_q - 7'h01; // RQ2 RQ9
         end
      end
   end

endmodule

/* design/rrv_top.sv */
`timescale 1ns/100ps
// Operation
// RQ1: On loss of signal, load the input's counter from the re-validation setting.
// RQ2: Count down one per valid consecutive period after the pre-divider.
// RQ3: A single missing edge during re-validation reloads the full count.
// RQ4: Counter reaching zero re-validates the input and clears its loss flag.
// RQ5: Setting codes 00/01/10/11 select 2, 16, 32 or 64 divided periods.
// RQ6: Raw period count scales with pre-divider ratio 1, 2, 4 or 8.
// RQ7: Each of the two inputs has its own counter and loss flag.
// RQ8: Automatic modes choose the reference from loss states and priorities.
// RQ9: Loss flag stays set until the counter has reached zero.
module rrv_top
   import rrv_pkg::*;
#(
   parameter int NUM_IN = 2,
   parameter int MISS_CYC = REF_MISS_CYC_CALC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [NUM_IN-1:0] REF_IN,
   input wire logic [1:0] REVALIDATION_COUNT_SELECT,
   input wire logic [NUM_IN-1:0][1:0] PREDIV_SELECT,
   input wire logic [1:0] INPUT_SELECTION_MODE,
   input wire logic MANUAL_INPUT_SELECT,
   input wire logic PRIORITY_INPUT,
   output logic [NUM_IN-1:0] SIGNAL_LOSS_FLAG,
   output logic [NUM_IN-1:0] REVAL_ACTIVE,
   output logic REF_SELECT,
   output logic HOLDOVER
);

   localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(MISS_CYC - 1);

   rrv_cfg_t cfg;
   logic [NUM_IN-1:0] signal_loss_flag;
   logic [NUM_IN-1:0] reval_run;
   rrv_sel_state_t state_q;
   rrv_sel_state_t state_d;

   always_comb begin
      cfg.count_sel = REVALIDATION_COUNT_SELECT;
      cfg.mode = INPUT_SELECTION_MODE;
      cfg.man_sel = MANUAL_INPUT_SELECT;
      cfg.prio_in = PRIORITY_INPUT;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_IN; g++) begin : g_in // RQ7
         logic prev_q;
         logic [PREDIV_W-1:0] div_q;
         logic [MISS_W-1:0] gap_q;
         logic period_ok_q;
         logic miss_q;
         logic [REVAL_CNT_W-1:0] cnt;
         logic rise;

         // Inputs are slow references sampled as synchronous levels
         assign rise = REF_IN[g] & ~prev_q;

         always_ff @(posedge CLK) begin
            if (RST) begin
               prev_q <= 1'b0;
            end else begin
               prev_q <= REF_IN[g];
            end
         end

         // Pre-divider: one valid period per 1, 2, 4 or 8 raw edges
         always_ff @(posedge CLK) begin
            if (RST) begin
               div_q <= 3'h0;
               period_ok_q <= 1'b0;
            end else if (miss_q) begin
               // An edge that lands with the miss pulse opens the new count instead of being lost
               div_q <= (rise && prediv_last(PREDIV_SELECT[g]) != 3'h0) ? 3'h1 : 3'h0;
               period_ok_q <= rise && (prediv_last(PREDIV_SELECT[g]) == 3'h0); // RQ3
            end else if (rise) begin
               if (div_q >= prediv_last(PREDIV_SELECT[g])) begin
                  div_q <= 3'h0;
                  period_ok_q <= 1'b1; // RQ6
               end else begin
                  div_q <= div_q + 3'h1;
                  period_ok_q <= 1'b0;
               end
            end else begin
               period_ok_q <= 1'b0;
            end
         end

         // Watchdog on raw edges; a gap longer than MISS_CYC clock cycles is a missing edge
         always_ff @(posedge CLK) begin
            if (RST) begin
               gap_q <= '0;
               miss_q <= 1'b0;
            end else if (rise) begin
               gap_q <= '0;
               miss_q <= 1'b0;
            end else if (gap_q >= MISS_LAST) begin
               gap_q <= '0;
               miss_q <= 1'b1; // RQ3
            end else begin
               gap_q <= gap_q + 16'h0001;
               miss_q <= 1'b0;
            end
         end

         rrv_channel u_chan (
            .clk(CLK),
            .rst(RST),
            .period_ok(period_ok_q), // RQ2
            .edge_miss(miss_q), // RQ1
            .count_sel(cfg.count_sel), // RQ5
            .los_q(signal_loss_flag[g]),
            .cnt_q(cnt)
         );

         assign reval_run[g] = signal_loss_flag[g] && (cnt != reval_load(cfg.count_sel));
      end
   endgenerate

   // Reference selection; automatic modes are revertive to the priority input
   always_comb begin
      state_d = state_q;
      if (cfg.mode[MODE_AUTO_BIT]) begin
         if (!signal_loss_flag[cfg.prio_in]) begin
            state_d = cfg.prio_in ? SEL_CLK1 : SEL_CLK0; // RQ8
         end else if (!signal_loss_flag[~cfg.prio_in]) begin
            state_d = cfg.prio_in ? SEL_CLK0 : SEL_CLK1; // RQ8
         end else if (cfg.mode == MODE_AUTO_HOLD) begin
            state_d = SEL_HOLD;
         end else if (state_q == SEL_HOLD) begin
            // Without holdover a selection still in hold moves to the priority input
            state_d = cfg.prio_in ? SEL_CLK1 : SEL_CLK0;
         end
      end else begin
         if (cfg.mode == MODE_SHORT_HOLD && signal_loss_flag[cfg.man_sel]) begin
            state_d = SEL_HOLD;
         end else begin
            state_d = cfg.man_sel ? SEL_CLK1 : SEL_CLK0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_q <= SEL_CLK0;
         REF_SELECT <= 1'b0;
         HOLDOVER <= 1'b0;
      end else begin
         state_q <= state_d;
         REF_SELECT <= (state_d == SEL_CLK1);
         HOLDOVER <= (state_d == SEL_HOLD);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         SIGNAL_LOSS_FLAG <= '1;
         REVAL_ACTIVE <= '0;
      end else begin
         SIGNAL_LOSS_FLAG <= signal_loss_flag; // RQ9
         REVAL_ACTIVE <= reval_run;
      end
   end

endmodule

/* test/rrv_properties.sv */
`timescale 1ns/100ps
module rrv_chk
   import rrv_pkg::*;
#(
   parameter int MISS_CYC = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [1:0] REF_IN,
   input wire logic [1:0] REVALIDATION_COUNT_SELECT,
   input wire logic [1:0][1:0] PREDIV_SELECT,
   input wire logic [1:0] INPUT_SELECTION_MODE,
   input wire logic PRIORITY_INPUT,
   input wire logic [1:0] SIGNAL_LOSS_FLAG,
   input wire logic [1:0] REVAL_ACTIVE,
   input wire logic REF_SELECT
);
   logic [1:0] p_q;
   logic [1:0] miss_m;
   logic [7:0] gap_m [2];
   logic [7:0] idle_q [2];
   logic [9:0] edg_q [2];
   logic [9:0] need [2];
   wire logic [1:0] rise = REF_IN & ~p_q;
   wire logic [9:0] base = (REVALIDATION_COUNT_SELECT == 2'h0) ? 10'h002 :
      10'h008 << REVALIDATION_COUNT_SELECT;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Edge tally restarts at each missing-edge event; an edge landing with it opens the new tally
   always_ff @(posedge CLK) begin
      p_q <= RST ? 2'b00 : REF_IN;
      for (int i = 0; i < 2; i++) begin
         idle_q[i] <= (RST || rise[i]) ? 8'h00 : idle_q[i] + {7'h00, idle_q[i] != 8'hFF};
         gap_m[i] <= (RST || rise[i] || gap_m[i] >= 8'(MISS_CYC - 1)) ? 8'h00 : gap_m[i] + 8'h01;
         miss_m[i] <= !RST && !rise[i] && gap_m[i] >= 8'(MISS_CYC - 1);
         edg_q[i] <= RST ? 10'h000 :
            (miss_m[i] ? 10'h000 : edg_q[i]) + {9'h000, rise[i]};
      end
   end
   always_comb begin
      for (int i = 0; i < 2; i++) need[i] = base << PREDIV_SELECT[i];
   end
   dead_sets_a: assert property (idle_q[0] == 8'(MISS_CYC + 4) |-> SIGNAL_LOSS_FLAG[0])
      else $error("no loss flag");
   stays_set_a: assert property (SIGNAL_LOSS_FLAG[0] && idle_q[0] > 8'h02 |=> SIGNAL_LOSS_FLAG[0])
      else $error("flag cleared early");
   clear_edge_a: assert property ($fell(SIGNAL_LOSS_FLAG[0]) |-> $past(rise[0], 3))
      else $error("clear not after edge");
   count_zero_a: assert property ($fell(SIGNAL_LOSS_FLAG[0]) |-> $past(edg_q[0], 2) == need[0])
      else $error("wrong count input 0");
   count_one_a: assert property ($fell(SIGNAL_LOSS_FLAG[1]) |-> $past(edg_q[1], 2) == need[1])
      else $error("wrong count input 1");
   active_flag_a: assert property (REVAL_ACTIVE[0] && idle_q[0] > 8'h02 |-> SIGNAL_LOSS_FLAG[0])
      else $error("active without flag");
   active_first_a: assert property ($fell(SIGNAL_LOSS_FLAG[0]) |-> $past(REVAL_ACTIVE[0]))
      else $error("clear without active count");
   auto_alt_a: assert property ((INPUT_SELECTION_MODE == MODE_AUTO && !PRIORITY_INPUT &&
      SIGNAL_LOSS_FLAG == 2'b01) [*3] |-> REF_SELECT) else $error("no switch");
   auto_prio_a: assert property ((INPUT_SELECTION_MODE == MODE_AUTO && !PRIORITY_INPUT &&
      SIGNAL_LOSS_FLAG == 2'b00) [*3] |-> !REF_SELECT) else $error("no revert");
endmodule

/* test/rrv_ref_src.sv */
`timescale 1ns/100ps
module rrv_ref_src (
   input wire logic clk,
   input wire logic [1:0] en,
   input wire logic [1:0] slow,
   output logic [1:0] ref_out
);
   logic [1:0] ph_q [2];
   // A stopped source sits low, like an unpowered oscillator
   initial ref_out = 2'h0;
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         ph_q[i] <= (en[i] && ph_q[i] != {slow[i], ~slow[i]}) ? ph_q[i] + 2'h1 : 2'h0;
         if (!en[i]) ref_out[i] <= 1'b0;
         else if (ph_q[i] == {slow[i], ~slow[i]}) ref_out[i] <= ~ref_out[i];
      end
   end
endmodule

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import rrv_pkg::*;
   logic clk = 1'b0, rst = 1'b1, man = 1'b0, prio = 1'b0, sel, hold;
   logic [1:0] code = 2'h0, mode = MODE_MANUAL, en = 2'h0, slow = 2'h0, ref_in, flag;
   logic [1:0][1:0] pdiv = '0;
   logic [15:0] tbl [4] = '{16'h0002, 16'h0010, 16'h0020, 16'h0040};
   int fails = 0, checks_done = 0, cyc = 0;
   always #25 clk = ~clk;
   rrv_ref_src src (.clk(clk), .en(en), .slow(slow), .ref_out(ref_in));
   rrv_top #(.MISS_CYC(8)) dut (.CLK(clk), .RST(rst), .REF_IN(ref_in),
      .REVALIDATION_COUNT_SELECT(code), .PREDIV_SELECT(pdiv), .INPUT_SELECTION_MODE(mode),
      .MANUAL_INPUT_SELECT(man), .PRIORITY_INPUT(prio), .SIGNAL_LOSS_FLAG(flag),
      .REVAL_ACTIVE(), .REF_SELECT(sel), .HOLDOVER(hold));
   task automatic chk(string s, logic [15:0] v, logic [15:0] x);
      checks_done++;
      if (v !== x) begin
         fails++;
         $display("BAD %s exp %0h seen %0h", s, x, v);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         summarize();
      end
   end
   // Counts raw edges until the flag drops; edges after the drop are not counted
   task automatic count(int i, output int e);
      logic p;
      p = 1'b0;
      e = 0;
      for (int k = 0; k < 4000 && flag[i] !== 1'b0; k++) begin
         @(posedge clk);
         #1 e += (ref_in[i] && !p && flag[i]) ? 1 : 0;
         p = ref_in[i];
      end
   endtask
   task automatic do_reset();
      int e;
      rst <= 1'b1;
      en <= 2'h0;
      pdiv <= '0;
      code <= 2'h0;
      mode <= MODE_MANUAL;
      prio <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("flag rst", flag, 2'h3);
      @(posedge clk);
      rst <= 1'b0;
      en <= 2'h3;
      count(0, e);
      chk("start edges", e, 16'h0002);
      chk("flag up", flag, 2'h0);
      @(posedge clk);
   endtask
   task automatic reval(int i, logic [1:0] c, logic [1:0] d, bit gap);
      int e;
      code <= c;
      pdiv[i] <= d;
      slow[i] <= d[0];
      en[i] <= 1'b0;
      repeat (20) @(posedge clk);
      #1 chk("flag lost", flag, i ? 2'h2 : 2'h1);
      @(posedge clk);
      en[i] <= 1'b1;
      if (gap) begin
         repeat (6) @(posedge clk);
         en[i] <= 1'b0;
         repeat (14) @(posedge clk);
         #1 chk("flag gap", flag[i], 1'b1);
         @(posedge clk);
         en[i] <= 1'b1;
      end
      count(i, e);
      chk("edges", e, tbl[c] << d);
      @(posedge clk);
   endtask
   task automatic auto_sel();
      mode <= MODE_AUTO;
      repeat (5) @(posedge clk);
      #1 chk("sel prio", sel, 1'b0);
      @(posedge clk);
      en[0] <= 1'b0;
      repeat (20) @(posedge clk);
      #1 chk("sel alt", sel, 1'b1);
      @(posedge clk);
      en <= 2'h1;
      mode <= MODE_SHORT_HOLD;
      man <= 1'b1;
      repeat (20) @(posedge clk);
      #1 chk("holdover", {flag, hold}, 3'h5);
      @(posedge clk);
      prio <= 1'b1;
      mode <= MODE_AUTO;
      repeat (5) @(posedge clk);
      #1 chk("sel prio lost", sel, 1'b0);
      @(posedge clk);
      en <= 2'h3;
      mode <= MODE_AUTO_HOLD;
      repeat (60) @(posedge clk);
      #1 chk("sel revert", {sel, hold}, 2'h2);
      @(posedge clk);
      en <= 2'h0;
      repeat (20) @(posedge clk);
      #1 chk("auto hold", {flag, hold}, 3'h7);
      @(posedge clk);
   endtask
   initial begin
      do_reset();
      for (int c = 0; c < 4; c++) begin
         for (int d = 0; d < 4; d++) reval(0, 2'(c), 2'(d), 1'b0);
      end
      reval(0, 2'h1, 2'h0, 1'b1);
      reval(1, 2'h0, 2'h2, 1'b0);
      auto_sel();
      do_reset();
      summarize();
   end
endmodule
bind rrv_top rrv_chk #(.MISS_CYC(MISS_CYC)) props (.*);
